// ---- aie_pkg.sv ----
// constants for the converter interrupt enable and status block
package aie_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AIE_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] AIE_ENABLE_OFFSET = 8'h04;
  localparam logic [7:0] AIE_START_OFFSET = 8'h08;
  localparam logic [31:0] AIE_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] AIE_ENABLE_RESET = 32'h00000000;
  localparam logic [1:0] AIE_START_RESET = 2'h0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AIE_NUM_SRC = 11;
  localparam int AIE_BIT_READY = 0;
  localparam int AIE_BIT_SAMPLING_END = 1;
  localparam int AIE_BIT_REG_CONV_END = 2;
  localparam int AIE_BIT_REG_SEQ_END = 3;
  localparam int AIE_BIT_OVERRUN = 4;
  localparam int AIE_BIT_INJ_CONV_END = 5;
  localparam int AIE_BIT_INJ_SEQ_END = 6;
  localparam int AIE_BIT_WD_ONE = 7;
  localparam int AIE_BIT_WD_TWO = 8;
  localparam int AIE_BIT_WD_THREE = 9;
  localparam int AIE_BIT_QUEUE_OVF = 10;
  localparam int AIE_BIT_REG_START = 0;
  localparam int AIE_BIT_INJ_START = 1;
endpackage

// ---- aie_irq_enable.sv ----
// interrupt enable, event flags and request gating for one converter
`timescale 1ns/1ns
`default_nettype none
module aie_irq_enable
  import aie_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // event pulses from the conversion engine, one per status bit
  input wire logic [AIE_NUM_SRC-1:0] event_set,
  // conversion engine clears the conversion end flags on data reads
  input wire logic regular_data_read,
  input wire logic injected_data_read,
  // conversion in progress, as the engine sees it
  input wire logic regular_start_bit,
  input wire logic injected_start_bit,
  // interrupt request
  output logic irq_req
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 8)
  begin : g_bad_addr
    $error("ADDR_W must lie between 4 and 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AIE_NUM_SRC-1:0] flag;
    logic [AIE_NUM_SRC-1:0] enable;
    logic [31:0] rdata;
    logic irq;
  } aie_state_t;

  aie_state_t s_q;
  aie_state_t s_d;

  logic hit_status;
  logic hit_enable;
  logic hit_start;
  logic [AIE_NUM_SRC-1:0] clr_mask;
  logic [AIE_NUM_SRC-1:0] set_mask;
  logic overrun_now;

  assign hit_status = reg_addr == AIE_STATUS_OFFSET[ADDR_W-1:0];
  assign hit_enable = reg_addr == AIE_ENABLE_OFFSET[ADDR_W-1:0];
  assign hit_start = reg_addr == AIE_START_OFFSET[ADDR_W-1:0];

  // a new regular result while the previous one is unread is an overrun
  assign overrun_now = event_set[AIE_BIT_REG_CONV_END] &
                       s_q.flag[AIE_BIT_REG_CONV_END];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    clr_mask = '0;
    if (reg_wr && hit_status)
    begin
      clr_mask = reg_wdata[AIE_NUM_SRC-1:0];
    end
    clr_mask[AIE_BIT_REG_CONV_END] = clr_mask[AIE_BIT_REG_CONV_END] | regular_data_read;
    clr_mask[AIE_BIT_INJ_CONV_END] = clr_mask[AIE_BIT_INJ_CONV_END] | injected_data_read;
    set_mask = event_set;
    set_mask[AIE_BIT_OVERRUN] = event_set[AIE_BIT_OVERRUN] | overrun_now;
    // set wins over a clear in the same cycle so no event is lost
    s_d.flag = (s_q.flag & ~clr_mask) | set_mask;
    if (reg_wr && hit_enable)
    begin
      // the start-bit conditions on writes are software's to keep
      s_d.enable = reg_wdata[AIE_NUM_SRC-1:0];
    end
    s_d.rdata = '0;
    if (reg_rd)
    begin
      if (hit_status)
      begin
        s_d.rdata[AIE_NUM_SRC-1:0] = s_q.flag;
      end
      else if (hit_enable)
      begin
        s_d.rdata[AIE_NUM_SRC-1:0] = s_q.enable;
      end
      else if (hit_start)
      begin
        s_d.rdata[AIE_BIT_REG_START] = regular_start_bit;
        s_d.rdata[AIE_BIT_INJ_START] = injected_start_bit;
      end
    end
    // registered request from next-state flag and enable: it rises on the same edge as the flag and enable registers
    s_d.irq = |(s_d.flag & s_d.enable);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_q.flag <= AIE_STATUS_RESET[AIE_NUM_SRC-1:0];
      s_q.enable <= AIE_ENABLE_RESET[AIE_NUM_SRC-1:0];
      s_q.rdata <= '0;
      s_q.irq <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // each source feeds the request through its own enable bit
  assign reg_rdata = s_q.rdata;
  assign irq_req = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the request is registered from next-state values, so it matches flag and enable on the same edge
  chk_irq_follows_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_req == |($past(s_d.flag) & $past(s_d.enable)))
    else $error("request does not match gated flags");

  chk_enable_reset_zero: assert property (@(posedge ref_clk)
    $past(!rstn) |-> s_q.enable == '0)
    else $error("enable not zero after reset");

  chk_enable_rd_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && hit_enable |=> reg_rdata[31:AIE_NUM_SRC] == '0 &&
    reg_rdata[AIE_NUM_SRC-1:0] == $past(s_q.enable))
    else $error("enable readback wrong");

  chk_flag_clear_w1: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && hit_status && reg_wdata[AIE_BIT_QUEUE_OVF] && !event_set[AIE_BIT_QUEUE_OVF]
    |=> !s_q.flag[AIE_BIT_QUEUE_OVF])
    else $error("write one did not clear flag");

  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_WD_ONE] |=> s_q.flag[AIE_BIT_WD_ONE] ##1
    (s_q.flag[AIE_BIT_WD_ONE] || $past(reg_wr)))
    else $error("flag set lost");

  chk_overrun_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_REG_CONV_END] && s_q.flag[AIE_BIT_REG_CONV_END]
    |=> s_q.flag[AIE_BIT_OVERRUN])
    else $error("overrun not flagged");

  chk_masked_no_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_q.enable == '0 && $past(s_q.enable == '0) && !$past(reg_wr) |-> !irq_req)
    else $error("request with all enables off");

  chk_status_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && hit_status |=> reg_rdata == {21'h000000, $past(s_q.flag)})
    else $error("status readback wrong");

  chk_irq_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_req && !reg_wr && !regular_data_read && !injected_data_read |=> irq_req)
    else $error("request dropped without a clear");

  // ----------------------------------------------------------------
  // reset and bus checks
  // ----------------------------------------------------------------
  // read data stand for exactly one cycle and are zero otherwise
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rdata[31:AIE_NUM_SRC] == '0)
    else $error("reserved bits not zero");

  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && !hit_status && !hit_enable && !hit_start |=> reg_rdata == '0)
    else $error("unmapped read not zero");

  // the start bits are the engine's; writes there must not disturb anything
  chk_start_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && hit_start |=> reg_rdata == {30'h0, $past(injected_start_bit),
    $past(regular_start_bit)})
    else $error("start bit readback wrong");

  chk_start_wr_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && hit_start |=> $stable(s_q.enable))
    else $error("write to start register changed enables");

  // reset loads constants only, so the first edge after release is clean
  chk_reset_outputs: assert property (@(posedge ref_clk)
    $past(!rstn) |-> !irq_req && reg_rdata == '0 && s_q.flag == '0)
    else $error("outputs not idle after reset");

  // ----------------------------------------------------------------
  // per-rule gating: an enabled event requests one cycle later
  // ----------------------------------------------------------------
  // an enable write in the same cycle may mask the source, so it is excluded
  chk_queue_ovf_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_QUEUE_OVF] && s_q.enable[AIE_BIT_QUEUE_OVF] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("queue overflow request missing");

  chk_wd_one_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_WD_ONE] && s_q.enable[AIE_BIT_WD_ONE] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("watchdog one request missing");

  chk_wd_two_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_WD_TWO] && s_q.enable[AIE_BIT_WD_TWO] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("watchdog two request missing");

  chk_wd_three_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_WD_THREE] && s_q.enable[AIE_BIT_WD_THREE] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("watchdog three request missing");

  chk_inj_seq_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_INJ_SEQ_END] && s_q.enable[AIE_BIT_INJ_SEQ_END] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("injected sequence request missing");

  chk_inj_conv_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_INJ_CONV_END] && s_q.enable[AIE_BIT_INJ_CONV_END]
    && !(reg_wr && hit_enable) |=> irq_req)
    else $error("injected conversion request missing");

  chk_overrun_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_OVERRUN] && s_q.enable[AIE_BIT_OVERRUN] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("overrun request missing");

  chk_reg_seq_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_REG_SEQ_END] && s_q.enable[AIE_BIT_REG_SEQ_END] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("regular sequence request missing");

  chk_reg_conv_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_REG_CONV_END] && s_q.enable[AIE_BIT_REG_CONV_END]
    && !(reg_wr && hit_enable) |=> irq_req)
    else $error("regular conversion request missing");

  chk_sampling_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_SAMPLING_END] && s_q.enable[AIE_BIT_SAMPLING_END]
    && !(reg_wr && hit_enable) |=> irq_req)
    else $error("sampling end request missing");

  chk_ready_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    event_set[AIE_BIT_READY] && s_q.enable[AIE_BIT_READY] && !(reg_wr && hit_enable)
    |=> irq_req)
    else $error("ready request missing");

  // ----------------------------------------------------------------
  // per-source checks
  // ----------------------------------------------------------------
  // only the two conversion end flags have a second clear path from the engine
  for (genvar g = 0; g < AIE_NUM_SRC; g++)
  begin : g_src_chk
    logic engine_clr;
    if (g == AIE_BIT_REG_CONV_END)
    begin : g_reg_clr
      assign engine_clr = regular_data_read;
    end
    else if (g == AIE_BIT_INJ_CONV_END)
    begin : g_inj_clr
      assign engine_clr = injected_data_read;
    end
    else
    begin : g_no_clr
      assign engine_clr = 1'b0;
    end

    chk_src_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
      event_set[g] |=> s_q.flag[g])
      else $error("flag event lost");

    // set beats clear, so the write-one check steps aside on an event
    chk_src_write_one: assert property (@(posedge ref_clk) disable iff (!rstn)
      reg_wr && hit_status && reg_wdata[g] && !event_set[g] && !overrun_now
      |=> !s_q.flag[g])
      else $error("write one left flag set");

    chk_src_flag_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_q.flag[g] && !(reg_wr && hit_status && reg_wdata[g]) && !engine_clr
      |=> s_q.flag[g])
      else $error("flag cleared without a clear");

    chk_src_no_spurious: assert property (@(posedge ref_clk) disable iff (!rstn)
      !s_q.flag[g] && !event_set[g] && !overrun_now |=> !s_q.flag[g])
      else $error("flag set without an event");

    // a data read clears like a write of one, and an event still wins
    chk_src_engine_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
      engine_clr && !event_set[g] |=> !s_q.flag[g])
      else $error("data read did not clear flag");

    chk_src_enable_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      reg_wr && hit_enable |=> s_q.enable[g] == $past(reg_wdata[g]))
      else $error("enable write not taken");

    chk_src_enable_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(reg_wr && hit_enable) |=> $stable(s_q.enable[g]))
      else $error("enable changed without a write");

    chk_src_status_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
      reg_rd && hit_status |=> reg_rdata[g] == $past(s_q.flag[g]))
      else $error("status bit readback wrong");

    chk_src_enable_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
      reg_rd && hit_enable |=> reg_rdata[g] == $past(s_q.enable[g]))
      else $error("enable bit readback wrong");
  end

endmodule
`default_nettype wire

// ---- aie_irq_enable_test.sv ----
// self-checking bench for the converter interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module aie_irq_enable_test;
  import aie_pkg::*;
  logic ref_clk, rstn, reg_wr, reg_rd, irq_req, rdr, idr, rsb, isb;
  logic pend = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [10:0] event_set, flg, en;
  logic [32:0] exq[$];
  int n_fail, total_checks, seed, i;
  int cyc = 0;
  aie_irq_enable DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_set(event_set), .regular_data_read(rdr), .injected_data_read(idr),
    .regular_start_bit(rsb), .injected_start_bit(isb), .irq_req(irq_req));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // bus and event drivers, each keeping the expected state
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == AIE_ENABLE_OFFSET) en = d[10:0];
    if (a == AIE_STATUS_OFFSET) flg = flg & ~d[10:0];
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == AIE_STATUS_OFFSET) v = {21'h0, flg};
    if (a == AIE_ENABLE_OFFSET) v = {21'h0, en};
    if (a == AIE_START_OFFSET) v = {30'h0, isb, rsb};
    exq.push_back({|(flg & en), v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ev(input logic [10:0] e);
    if (e[2] && flg[2]) flg[4] = 1'b1;
    flg = flg | e;
    event_set <= e;
    @(posedge ref_clk);
    event_set <= 11'h000;
    @(posedge ref_clk);
  endtask
  task automatic dr(input logic r, input logic j);
    if (r) flg[2] = 1'b0;
    if (j) flg[5] = 1'b0;
    rdr <= r;
    idr <= j;
    @(posedge ref_clk);
    rdr <= 1'b0;
    idr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // result watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    pend <= reg_rd;
    cyc <= cyc + 1;
    if (pend) check({irq_req, reg_rdata}, exq.pop_front());
    if (cyc > 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    seed = 72674;
    {rstn, reg_wr, reg_rd, rdr, idr, rsb, isb} = 7'h00;
    {reg_addr, reg_wdata, event_set, flg, en} = 73'h0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00);
    rd(8'h04);
    rd(8'h0C);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04);
    $display("reset and reserved test done");
    // start bits low while enables change
    for (i = 0; i < 11; i++)
    begin
      wr(8'h04, 32'h1 << i);
      ev(11'h001 << ((i + 1) % 11));
      rd(8'h00);
      ev(11'h001 << i);
      rd(8'h00);
      wr(8'h00, 32'h7FF);
      rd(8'h00);
    end
    $display("per source gating test done");
    wr(8'h04, 32'h14);
    ev(11'h004);
    ev(11'h024);
    rd(8'h00);
    dr(1'b1, 1'b1);
    rd(8'h00);
    wr(8'h00, 32'h0);
    rd(8'h00);
    $display("overrun and data read test done");
    for (i = 0; i < 4; i++)
    begin
      rsb <= i[0];
      isb <= i[1];
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08);
      rd(8'h04);
    end
    rsb <= 1'b0;
    isb <= 1'b0;
    repeat (40)
    begin
      wr(8'h04, $random(seed));
      ev(11'($random(seed)));
      rd(8'h00);
      wr(8'h00, $random(seed));
      rd(8'h00);
    end
    $display("start readback and random test done");
    wr(8'h04, 32'h7FF);
    ev(11'h7FF);
    rstn <= 1'b0;
    flg = 11'h000;
    en = 11'h000;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00);
    rd(8'h04);
    $display("mid-run reset test done");
    // let the watcher take the last read before the verdict
    @(posedge ref_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
